// ### bench/i2c_slave_receive_7bit_bench.sv
/*
  bench: apb software view of the two-wire slave and the master end,
  joined by twi_link_if, with the link checker alongside.
  assumes package and interface are compiled first.
*/
`timescale 1ns/1ps
module i2c_slave_receive_7bit_bench;
  import twi_rx_pkg::*;
  // ---------------------------------------------------------------
  // pins and counters
  // ---------------------------------------------------------------
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic go = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] byte_d = 8'h00;
  logic last = 1'b0;
  logic byte_take;
  logic nack;
  logic busy;
  logic [31:0] rdat;
  logic rerr;
  int mismatches = 0;
  int samples_checked = 0;
  twi_link_if link ();
  always #2 clk_in = ~clk_in;
  twi_slave_rx twi_slave_rx_i (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link));
  twi_master_tx #(.HALF(HALF_CYC)) twi_master_tx_i (.clk_in(clk_in), .nrst_in(nrst_in),
    .go_in(go), .addr_in(addr), .byte_in(byte_d), .last_in(last), .byte_take_out(byte_take),
    .nack_out(nack), .busy_out(busy), .link(link));
  twi_rx_monitor twi_rx_monitor_i (.clk_in(clk_in), .nrst_in(nrst_in), .scl(link.scl),
    .sda(link.sda), .m_sda_oe_n(link.m_sda_oe_n), .s_scl_o(link.s_scl_o),
    .s_scl_oe_n(link.s_scl_oe_n), .s_sda_o(link.s_sda_o), .s_sda_oe_n(link.s_sda_oe_n));
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  // one apb transfer; a idle cycle follows so calls never collide
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    // no assumed wait count: only the watchdog ends a missing answer
    while (pready !== 1'b1)
      @(posedge clk_in);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, APB_ZERO);
    cmp(name, e, rdat & m);
  endtask
  // software side of one byte event; irq cleared before release to avoid a lost event
  task automatic svc(input logic [7:0] m, input logic [7:0] st, input logic [7:0] b,
    input logic clock_release_bit, input logic [7:0] ctl);
    rdat = APB_ZERO;
    while (rdat[ST_IRQ] !== 1'b1)
      apb(1'b0, OFS_STATUS, APB_ZERO);
    cmp("status", {24'h0, st}, rdat & {24'h0, m});
    rdc("release", OFS_CTRL, 32'h2, {30'h0, clock_release_bit, 1'b0});
    rdc("buffer", OFS_RX_BUFFER, 32'hff, {24'h0, b});
    rdc("full", OFS_STATUS, 32'h1, APB_ZERO);
    apb(1'b1, OFS_STATUS, 32'h4);
    apb(1'b1, OFS_CTRL, {24'h0, ctl});
  endtask
  // master frame; byte_d moves on once the first byte is taken
  task automatic xfer(input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1,
    input logic one);
    addr <= a;
    byte_d <= d0;
    last <= one;
    go <= 1'b1;
    while (busy !== 1'b1)
      @(posedge clk_in);
    go <= 1'b0;
    while (busy === 1'b1 && byte_take !== 1'b1)
      @(posedge clk_in);
    byte_d <= d1;
    last <= 1'b1;
    while (busy !== 1'b0)
      @(posedge clk_in);
    // the slave's synchroniser sees the stop a few cycles after the master ends
    repeat (4) @(posedge clk_in);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  // watchdog: the sequence needs about 10 us
  initial
  begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    int i;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    rdc("ctrl", OFS_CTRL, 32'hff, {24'h0, CTRL_RESET});
    rdc("own", OFS_OWN_ADDR, 32'hff, {24'h0, ADDR_RESET});
    rdc("status", OFS_STATUS, 32'hff, APB_ZERO);
    apb(1'b0, 8'h10, APB_ZERO);
    cmp("slverr", 32'h1, {31'h0, rerr});
    cmp("unmapped", APB_ZERO, rdat);
    apb(1'b1, OFS_OWN_ADDR, 32'ha5);
    // two data bytes, no stretching
    fork
      xfer(7'h52, 8'h3c, 8'hc3, 1'b0);
      begin
        svc(8'h2d, 8'h0d, 8'ha4, 1'b1, 8'h02);
        svc(8'h05, 8'h05, 8'h3c, 1'b1, 8'h02);
        svc(8'h05, 8'h05, 8'hc3, 1'b1, 8'h02);
      end
    join
    cmp("nack", APB_ZERO, {31'h0, nack});
    rdc("stop", OFS_STATUS, 32'h10, 32'h10);
    // an unread byte refuses the next address unless overwrite is on
    fork
      xfer(7'h52, 8'h5a, 8'h00, 1'b1);
      svc(8'h05, 8'h05, 8'ha4, 1'b1, 8'h02);
    join
    apb(1'b1, OFS_STATUS, 32'h1e);
    xfer(7'h52, 8'h11, 8'h00, 1'b1);
    cmp("nack", 32'h1, {31'h0, nack});
    rdc("no irq", OFS_STATUS, 32'h05, 32'h01);
    apb(1'b1, OFS_STATUS, 32'h1e);
    apb(1'b1, OFS_CTRL, 32'h12);
    fork
      xfer(7'h52, 8'h33, 8'h00, 1'b1);
      svc(8'h05, 8'h05, 8'ha4, 1'b1, 8'h02);
    join
    rdc("kept", OFS_RX_BUFFER, 32'hff, 32'h33);
    rdc("full", OFS_STATUS, 32'h01, APB_ZERO);
    // foreign address: no interrupt, interrupt on start, interrupt on stop
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, OFS_STATUS, 32'h1e);
      apb(1'b1, OFS_CTRL, (i == 0) ? 32'h02 : ((i == 1) ? 32'h22 : 32'h42));
      xfer(7'h11, 8'h77, 8'h00, 1'b1);
      cmp("nack", 32'h1, {31'h0, nack});
      rdc("frame irq", OFS_STATUS, 32'h05, (i == 0) ? 32'h00 : 32'h04);
    end
    // both holds with stretch: address acked by software, byte refused
    apb(1'b1, OFS_STATUS, 32'h1e);
    apb(1'b1, OFS_CTRL, 32'h0f);
    fork
      xfer(7'h52, 8'h96, 8'h69, 1'b0);
      begin
        svc(8'h45, 8'h45, 8'ha4, 1'b0, 8'h0f);
        svc(8'h45, 8'h04, 8'ha4, 1'b0, 8'h0f);
        svc(8'h45, 8'h45, 8'h96, 1'b0, 8'h8f);
      end
    join
    cmp("nack", 32'h1, {31'h0, nack});
    rdc("no irq", OFS_STATUS, 32'h04, APB_ZERO);
    end_of_test();
  end
endmodule

// ### bench/twi_rx_monitor.sv
/*
  link checker for the two-wire receive path, watching the interface lines.
  assumes clk_in samples the resolved lines; the bench instantiates it.
*/
`timescale 1ns/1ps
module twi_rx_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // link lines and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe_n,
  input wire logic s_scl_o,
  input wire logic s_scl_oe_n,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n
);
  // ---------------------------------------------------------------
  // bit position tracker
  // ---------------------------------------------------------------
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic start_ev;
  logic stop_ev;
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev = scl & scl_q & ~sda_q & sda;
  // counts scl falls in a frame; 8 means the ack bit is on the wire.
  // start loads f so that the start's own scl fall is not counted as a bit
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt <= 4'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev)
        bit_cnt <= 4'hf;
      else if (scl_q && !scl)
        bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  chk_ack_start: assert property ($fell(s_sda_oe_n) |-> bit_cnt == 4'h8 && !scl)
    else $error("slave ack begins outside the ninth bit");
  chk_ack_release: assert property ($rose(s_sda_oe_n) |-> bit_cnt == 4'h0 && !scl)
    else $error("slave ack released at the wrong point");
  chk_ack_held: assert property (!s_sda_oe_n && scl |-> bit_cnt == 4'h8)
    else $error("slave pulls data during a data bit");
  chk_stretch_point: assert property ($fell(s_scl_oe_n) |->
    !scl && (bit_cnt == 4'h8 || bit_cnt == 4'h0))
    else $error("clock stretch starts at the wrong point");
  chk_open_drain: assert property (s_sda_o == 1'b0 && s_scl_o == 1'b0)
    else $error("slave drives a high level");
  chk_quiet_stop: assert property (stop_ev |=> s_sda_oe_n [*8])
    else $error("slave drives data after stop");
  chk_master_ack_free: assert property (scl && bit_cnt == 4'h8 |-> m_sda_oe_n)
    else $error("master holds data in the ack bit");
  chk_sda_stable_high: assert property (scl && scl_q && bit_cnt != 4'h0 |-> $stable(sda))
    else $error("data moves while clock is high");
  cov_ack: cover property ($fell(s_sda_oe_n));
  cov_stretch: cover property ($fell(s_scl_oe_n));
  cov_stop: cover property (stop_ev);
endmodule

// ### src/twi_link_if.sv
/*
  two-wire link between the bus master end and the slave end.
  open-drain: each side drives low when its enable is low; the interface
  resolves the wired-and level and feeds it back on scl/sda.
*/
`timescale 1ns/1ps
interface twi_link_if;
  logic scl;
  logic sda;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_scl_o;
  logic s_scl_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  // resolved wired-and bus level
  assign scl = (m_scl_oe_n | m_scl_o) & (s_scl_oe_n | s_scl_o);
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);
  modport master (input scl, sda, output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n);
  modport slave (input scl, sda, output s_scl_o, s_scl_oe_n, s_sda_o, s_sda_oe_n);
endinterface

// ### src/twi_master_tx.sv
/*
  bus master end: sends start, a seven-bit write address and data bytes,
  then stop. assumes the slave may stretch scl; the master waits for scl
  to read high before counting its high half.
*/
`timescale 1ns/1ps
module twi_master_tx
  import twi_rx_pkg::*;
#(
  parameter int HALF = HALF_CYC
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // user byte stream
  input wire logic go_in,
  input wire logic [6:0] addr_in,
  input wire logic [7:0] byte_in,
  input wire logic last_in,
  output logic byte_take_out,
  output logic nack_out,
  output logic busy_out,
  // link
  twi_link_if.master link
);
  typedef enum logic [2:0] {M_IDLE = 3'b000, M_START = 3'b001, M_LOW = 3'b011,
    M_HIGH = 3'b010, M_STOP = 3'b110} mstate_t;
  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    mstate_t st;
    logic [15:0] cnt;
    logic [3:0] bits;
    logic [7:0] sh;
    logic last;
    logic scl_low;
    logic sda_low;
    logic take;
    logic nack;
    logic busy;
  } mst_t;
  mst_t m_reg, m_next;
  logic done;

  // ---------------------------------------------------------------
  // bit engine; ninth bit is released for the slave's ack
  // ---------------------------------------------------------------
  always_comb
  begin
    m_next = m_reg;
    m_next.scl_sy = {m_reg.scl_sy[0], link.scl};
    m_next.sda_sy = {m_reg.sda_sy[0], link.sda};
    m_next.take = 1'b0;
    done = m_reg.cnt == 16'(HALF - 1);
    m_next.cnt = done ? 16'h0 : m_reg.cnt + 16'h1;
    case (m_reg.st)
      M_IDLE:
      begin
        m_next.cnt = 16'h0;
        if (go_in)
        begin
          m_next.st = M_START;
          m_next.sh = {addr_in, 1'b0};
          m_next.busy = 1'b1;
          m_next.nack = 1'b0;
          m_next.bits = 4'h0;
          m_next.last = 1'b0;
          m_next.sda_low = 1'b1;
        end
      end
      M_START:
        if (done)
        begin
          m_next.st = M_LOW;
          m_next.scl_low = 1'b1;
        end
      M_LOW:
        if (done)
        begin
          m_next.st = M_HIGH;
          m_next.scl_low = 1'b0;
        end
        else if (m_reg.cnt == 16'h0)
        begin
          m_next.sda_low = m_reg.bits == BITS_ADDR_DATA ? 1'b0 : ~m_reg.sh[7];
        end
      M_HIGH:
        // slave stretch: hold the count while scl still reads low
        if (!m_reg.scl_sy[1])
        begin
          m_next.cnt = 16'h0;
        end
        else if (done)
        begin
          m_next.scl_low = 1'b1;
          m_next.st = M_LOW;
          if (m_reg.bits == BITS_ADDR_DATA)
          begin
            m_next.nack = m_reg.sda_sy[1];
            m_next.bits = 4'h0;
            m_next.sh = byte_in;
            m_next.take = ~m_reg.sda_sy[1] & ~m_reg.last;
            m_next.last = last_in;
            if (m_reg.sda_sy[1] | m_reg.last)
            begin
              m_next.st = M_STOP;
              m_next.sda_low = 1'b1;
            end
          end
          else
          begin
            m_next.bits = m_reg.bits + 4'h1;
            m_next.sh = {m_reg.sh[6:0], 1'b0};
          end
        end
      M_STOP:
        if (done)
        begin
          if (m_reg.scl_low)
          begin
            m_next.scl_low = 1'b0;
          end
          else
          begin
            m_next.sda_low = 1'b0; // stop: sda rises, scl high
            m_next.st = M_IDLE;
            m_next.busy = 1'b0;
          end
        end
      default: m_next.st = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      m_reg <= '{scl_sy: 2'b11, sda_sy: 2'b11, st: M_IDLE, cnt: 16'h0, bits: 4'h0,
        sh: 8'h00, last: 1'b0, scl_low: 1'b0, sda_low: 1'b0, take: 1'b0, nack: 1'b0,
        busy: 1'b0};
    end
    else
    begin
      m_reg <= m_next;
    end
  end

  assign byte_take_out = m_reg.take;
  assign nack_out = m_reg.nack;
  assign busy_out = m_reg.busy;
  assign link.m_scl_o = 1'b0;
  assign link.m_sda_o = 1'b0;
  assign link.m_scl_oe_n = ~m_reg.scl_low;
  assign link.m_sda_oe_n = ~m_reg.sda_low;
endmodule

// ### src/twi_rx_pkg.sv
/*
  shared constants for the two-wire slave receive path and its master end:
  register offsets, bit positions, reset values and the link timing.
  assumes nothing beyond a SystemVerilog compiler.
*/
package twi_rx_pkg;
  // ---------------------------------------------------------------
  // apb register offsets of the slave's software view
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_RX_BUFFER = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_OWN_ADDR = 8'h0c;
  // ---------------------------------------------------------------
  // status bits (read, write 1 to clear the sticky ones)
  // ---------------------------------------------------------------
  localparam int ST_BF = 0;
  localparam int ST_OV = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_START = 3;
  localparam int ST_STOP = 4;
  localparam int ST_RW = 5;
  localparam int ST_ACK_TIME_FLAG = 6;
  localparam int ST_DA = 7;
  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  localparam int CT_SEN = 0;
  localparam int CT_CKP = 1;
  localparam int CT_ADDRESS_HOLD_ENABLE = 2;
  localparam int CT_DATA_HOLD_ENABLE = 3;
  localparam int CT_BUFFER_OVERWRITE_ENABLE = 4;
  localparam int CT_SCIE = 5;
  localparam int CT_PCIE = 6;
  localparam int CT_ACK_VALUE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h02;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  // ---------------------------------------------------------------
  // bit counts and master timing
  // ---------------------------------------------------------------
  localparam logic [3:0] BITS_ADDR_DATA = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam int CLK_MHZ = 250;
  localparam int HALF_NS = 32;
  localparam int HALF_CYC = HALF_NS * CLK_MHZ / 1000;
  localparam logic [31:0] APB_ZERO = 32'h0000_0000;
endpackage

// ### src/twi_slave_rx.sv
/*
  seven-bit two-wire slave, receive path, with apb register access.
  assumes the link pins are wired-and through twi_link_if and that
  scl/sda are asynchronous to clk_in; they are synchronised here.
*/
`timescale 1ns/1ps
module twi_slave_rx
  import twi_rx_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // link
  twi_link_if.slave link
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_SHIFT = 2'b01, S_ACK = 2'b11,
    S_SKIP = 2'b10} phase_t;
  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    phase_t phase;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic is_addr;
    logic ack_drive;
    logic hold_ack;
    logic [7:0] rxbuf;
    logic [7:0] status;
    logic [7:0] ctrl;
    logic [7:0] own;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic scl_low;
    logic sda_low;
  } state_t;
  state_t r_reg, r_next;
  logic scl_s, sda_s, scl_fall, scl_rise, start_c, stop_c, acc, wr1;
  logic addr_match, ovf;
  logic [31:0] rd;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // pins pass two flops; only the second stage feeds the edge logic
  always_comb
  begin
    r_next = r_reg;
    r_next.scl_sy = {r_reg.scl_sy[0], link.scl};
    r_next.sda_sy = {r_reg.sda_sy[0], link.sda};
    scl_s = r_reg.scl_sy[1];
    sda_s = r_reg.sda_sy[1];
    r_next.scl_d = scl_s;
    r_next.sda_d = sda_s;
    scl_fall = r_reg.scl_d & ~scl_s;
    scl_rise = ~r_reg.scl_d & scl_s;
    start_c = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s;
    stop_c = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s;
    addr_match = r_reg.shreg[7:1] == r_reg.own[7:1];
    ovf = (r_reg.status[ST_BF] | r_reg.status[ST_OV]) & ~r_reg.ctrl[CT_BUFFER_OVERWRITE_ENABLE];
    acc = psel_in & penable_in & ~r_reg.pready;
    wr1 = acc & pwrite_in;
    rd = APB_ZERO;
    // software side first so hardware sets below win over clears
    r_next.pready = acc;
    r_next.pslverr = 1'b0;
    case (paddr_in)
      OFS_RX_BUFFER: rd = {24'h0, r_reg.rxbuf};
      OFS_STATUS: rd = {24'h0, r_reg.status};
      OFS_CTRL: rd = {24'h0, r_reg.ctrl};
      OFS_OWN_ADDR: rd = {24'h0, r_reg.own};
      default: r_next.pslverr = acc;
    endcase
    r_next.prdata = acc ? rd : r_reg.prdata;
    if (acc & ~pwrite_in & paddr_in == OFS_RX_BUFFER)
    begin
      r_next.status[ST_BF] = 1'b0;
    end
    if (wr1 & paddr_in == OFS_STATUS) // software clears irq
    begin
      r_next.status[ST_OV] = r_reg.status[ST_OV] & ~pwdata_in[ST_OV];
      r_next.status[ST_IRQ] = r_reg.status[ST_IRQ] & ~pwdata_in[ST_IRQ];
      r_next.status[ST_START] = r_reg.status[ST_START] & ~pwdata_in[ST_START];
      r_next.status[ST_STOP] = r_reg.status[ST_STOP] & ~pwdata_in[ST_STOP];
    end
    if (wr1 & paddr_in == OFS_CTRL)
    begin
      r_next.ctrl = pwdata_in[7:0]; // ack value then release
    end
    if (wr1 & paddr_in == OFS_OWN_ADDR)
    begin
      r_next.own = pwdata_in[7:0];
    end
    // link framing
    if (start_c)
    begin
      r_next.status[ST_START] = 1'b1;
      r_next.status[ST_STOP] = 1'b0;
      if (r_reg.ctrl[CT_SCIE])
      begin
        r_next.status[ST_IRQ] = 1'b1;
      end
      r_next.phase = S_SHIFT;
      r_next.bits = 4'h0;
      r_next.is_addr = 1'b1;
      r_next.ack_drive = 1'b0;
    end
    else if (stop_c)
    begin
      r_next.status[ST_STOP] = 1'b1;
      r_next.status[ST_START] = 1'b0;
      if (r_reg.ctrl[CT_PCIE])
      begin
        r_next.status[ST_IRQ] = 1'b1;
      end
      r_next.phase = S_IDLE;
      r_next.ack_drive = 1'b0;
    end
    else
    begin
      case (r_reg.phase)
        S_SHIFT:
        begin
          if (scl_rise)
          begin
            r_next.shreg = {r_reg.shreg[6:0], sda_s};
            r_next.bits = r_reg.bits + 4'h1;
          end
          if (scl_fall & r_reg.bits == BITS_ADDR_DATA)
          begin
            r_next.phase = S_ACK;
            r_next.status[ST_ACK_TIME_FLAG] = 1'b1;
            if (r_reg.is_addr & (~addr_match | r_reg.shreg[0]))
            begin
              r_next.phase = S_SKIP; // foreign addresses and reads are not this block's
              r_next.status[ST_ACK_TIME_FLAG] = 1'b0; // no ack phase follows
            end
            else if (r_reg.is_addr ? r_reg.ctrl[CT_ADDRESS_HOLD_ENABLE] : r_reg.ctrl[CT_DATA_HOLD_ENABLE])
            begin
              r_next.hold_ack = 1'b1;
              r_next.status[ST_IRQ] = 1'b1;
              r_next.ctrl[CT_CKP] = 1'b0;
              r_next.rxbuf = r_reg.shreg;
              r_next.status[ST_BF] = 1'b1;
              r_next.status[ST_DA] = ~r_reg.is_addr;
              if (r_reg.is_addr)
              begin
                r_next.status[ST_RW] = 1'b0;
              end
            end
            else
            begin
              r_next.hold_ack = 1'b0;
              r_next.ack_drive = ~ovf;
              if (ovf)
              begin
                r_next.status[ST_OV] = 1'b1;
              end
              else
              begin
                r_next.rxbuf = r_reg.shreg;
                r_next.status[ST_BF] = 1'b1;
                r_next.status[ST_DA] = ~r_reg.is_addr;
                if (r_reg.is_addr)
                begin
                  r_next.status[ST_RW] = 1'b0;
                end
              end
            end
          end
        end
        S_ACK:
        begin
          // hold: drive software's ack value once clock is released
          if (r_reg.hold_ack & r_reg.ctrl[CT_CKP])
          begin
            r_next.ack_drive = ~r_reg.ctrl[CT_ACK_VALUE_BIT];
            r_next.hold_ack = 1'b0;
          end
          if (scl_fall & (~r_reg.hold_ack | r_reg.ctrl[CT_CKP]))
          begin
            r_next.status[ST_ACK_TIME_FLAG] = 1'b0;
            r_next.ack_drive = 1'b0;
            r_next.hold_ack = 1'b0;
            r_next.bits = 4'h0;
            r_next.is_addr = 1'b0;
            r_next.phase = r_reg.ack_drive ? S_SHIFT : S_SKIP;
            if (r_reg.ack_drive)
            begin
              r_next.status[ST_IRQ] = 1'b1;
              if (r_reg.ctrl[CT_SEN])
              begin
                r_next.ctrl[CT_CKP] = 1'b0;
              end
            end
          end
        end
        S_SKIP: r_next.phase = S_SKIP;
        default: r_next.phase = S_IDLE;
      endcase
    end
    // stretch at a byte boundary; a held ack keeps scl low one more cycle so sda settles first
    r_next.scl_low = ((~r_next.ctrl[CT_CKP] & (r_next.phase == S_ACK | r_next.phase == S_SHIFT)
      & (r_next.bits == 4'h0 | r_next.bits == BITS_ADDR_DATA)) | (r_next.phase == S_ACK
      & r_reg.hold_ack)) & ~scl_s;
    r_next.sda_low = r_next.ack_drive;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      r_reg <= '{scl_sy: 2'b11, sda_sy: 2'b11, scl_d: 1'b1, sda_d: 1'b1,
        phase: S_IDLE, bits: 4'h0, shreg: 8'h00, is_addr: 1'b0, ack_drive: 1'b0,
        hold_ack: 1'b0, rxbuf: 8'h00, status: 8'h00, ctrl: CTRL_RESET,
        own: ADDR_RESET, prdata: APB_ZERO, pready: 1'b0, pslverr: 1'b0,
        scl_low: 1'b0, sda_low: 1'b0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops; drive value always low, enable active low
  assign prdata_out = r_reg.prdata;
  assign pready_out = r_reg.pready;
  assign pslverr_out = r_reg.pslverr;
  assign link.s_scl_o = 1'b0;
  assign link.s_sda_o = 1'b0;
  assign link.s_scl_oe_n = ~r_reg.scl_low;
  assign link.s_sda_oe_n = ~r_reg.sda_low;
endmodule
